/* File: shared/hs_clock_cfg.svh */
`ifndef HS_CLOCK_CFG_SVH
`define HS_CLOCK_CFG_SVH

// Register byte addresses
`define HCS_ADDR 16'hf002
`define LCS_ADDR 16'hf004

// Reset values
`define HCS_RESET 16'h0373
`define LCS_RESET 16'h0002
`define HDIV_RESET 3'h3
`define HMODE_RESET 2'h2
`define ODIV_RESET 3'h3
`define SYSSEL_RESET 1'b1
`define HOSCEN_RESET 1'b1
`define LPERMIT_RESET 1'b0
`define LMODE_RESET 2'h2

// Main register field positions
`define HDIV_LSB 0
`define HDIV_MSB 2
`define HMODE_LSB 3
`define HMODE_MSB 4
`define ODIV_LSB 5
`define ODIV_MSB 7
`define SYSSEL_BIT 8
`define HOSCEN_BIT 9
`define LPERMIT_BIT 11
`define LSTABLE_BIT 14
`define HSTABLE_BIT 15

// Low-speed register field positions
`define LMODE_LSB 0
`define LMODE_MSB 1
`define LFLT_BIT 4
`define HFLT_LSB 6
`define HFLT_MSB 7

// Mode codes shared by both mode fields
`define MODE_HOLD 2'h0
`define MODE_XTAL 2'h1
`define MODE_RC 2'h2
`define MODE_EXT 2'h3

// Divider codes and prescaler width
`define DIV_MAX_CODE 3'h5
`define PRESCALE_W 5
`define PRESCALE_LAST 5'h1f

`endif

/* File: shared/hs_clock_pkg.sv */
package hs_clock_pkg;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [1:0] byte_en;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic sys;
      logic hs;
      logic port_out;
      logic timer_ls;
      logic peri_ls;
   } clk_en_t;

   typedef struct packed {
      logic hs_osc_run;
      logic [1:0] hs_mode;
      logic ls_xtal_run;
      logic [1:0] ls_mode;
      logic ls_filter;
      logic [1:0] hs_filter;
   } osc_ctl_t;

   typedef enum logic {
      SRC_LOW,
      SRC_HIGH
   } sys_src_t;

endpackage

/* File: verilog/hs_clock_system_select.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "hs_clock_cfg.svh"
`default_nettype none

module hs_clock_system_select
   import hs_clock_pkg::*;
(
   // Clock and reset; sys_clk is the oscillator clock
   input wire logic sys_clk,
   input wire logic nrst,
   // Register port
   input wire reg_req_t bus_req,
   output logic [15:0] bus_rdata,
   // Low-speed sources and oscillator status
   input wire logic ls_sel_tick,
   input wire logic ls_xtal_tick,
   input wire logic hs_osc_stable,
   input wire logic ls_osc_stable,
   // Clock enables and oscillator control
   output clk_en_t clk_en,
   output osc_ctl_t osc_ctl
);

   // Main register fields, one flop group per concern
   logic [2:0] hdiv_q;
   logic [1:0] hmode_q;
   logic [2:0] odiv_q;
   logic syssel_q;
   logic hoscen_q;
   logic permit_q;
   // Bits 13, 12 and 10 are plain storage with no function
   logic [2:0] spare_q;

   // Low-speed register: mode field plus filter selects and storage above it
   logic [1:0] lmode_q;
   logic [13:0] lcs_store_q;

   logic [`PRESCALE_W-1:0] pre_q;
   logic [2:0] hdiv_act_q;
   logic [2:0] odiv_act_q;
   sys_src_t src_q;
   logic hstab_q;
   logic lstab_q;

   logic wr_hcs_lo;
   logic wr_hcs_hi;
   logic wr_lcs_lo;
   logic wr_lcs_hi;
   logic rate_load;
   logic hs_tick;
   logic out_tick;
   logic [15:0] hcs_word;
   logic [15:0] lcs_word;

   // Tick when the low bits of the prescaler are all ones
   function automatic logic div_tick(input logic [2:0] code,
                                     input logic [`PRESCALE_W-1:0] cnt);
      logic [`PRESCALE_W-1:0] mask;
      logic [2:0] c;
      c = (code > `DIV_MAX_CODE) ? `DIV_MAX_CODE : code;
      mask = `PRESCALE_W'((6'h01 << c) - 6'h01);
      div_tick = ((cnt & mask) == mask);
   endfunction

   // Mode write: 00 keeps the old value
   function automatic logic [1:0] mode_next(input logic [1:0] old,
                                            input logic [1:0] wr_val);
      mode_next = (wr_val == `MODE_HOLD) ? old : wr_val;
   endfunction

   // Address decode shared by the write lanes and the read mux
   function automatic logic reg_hit(input logic [15:0] addr,
                                    input logic [15:0] target);
      reg_hit = (addr == target);
   endfunction

   // Low-speed crystal runs for its own mode or when the timer permit asks for it
   function automatic logic ls_xtal_on(input logic permit,
                                       input logic [1:0] mode);
      ls_xtal_on = permit || (mode == `MODE_XTAL);
   endfunction

   assign wr_hcs_lo = bus_req.wr && bus_req.byte_en[0] && reg_hit(bus_req.addr, `HCS_ADDR);
   assign wr_hcs_hi = bus_req.wr && bus_req.byte_en[1] && reg_hit(bus_req.addr, `HCS_ADDR);
   assign wr_lcs_lo = bus_req.wr && bus_req.byte_en[0] && reg_hit(bus_req.addr, `LCS_ADDR);
   assign wr_lcs_hi = bus_req.wr && bus_req.byte_en[1] && reg_hit(bus_req.addr, `LCS_ADDR);
   assign hs_tick = div_tick(hdiv_act_q, pre_q);
   assign out_tick = div_tick(odiv_act_q, pre_q);
   assign rate_load = (pre_q == `PRESCALE_LAST) || !hoscen_q;

   // Register images as software sees them
   assign hcs_word = {hstab_q, lstab_q, spare_q[2:1], permit_q, spare_q[0],
                      hoscen_q, syssel_q, odiv_q, hmode_q, hdiv_q};
   assign lcs_word = {lcs_store_q, lmode_q};

   // High-speed divider code; forbidden codes are kept and decoded as 32
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hdiv_q <= `HDIV_RESET;
      end
      else if (wr_hcs_lo)
      begin
         hdiv_q <= bus_req.wdata[`HDIV_MSB:`HDIV_LSB];
      end
   end

   // Output clock divider code
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         odiv_q <= `ODIV_RESET;
      end
      else if (wr_hcs_lo)
      begin
         odiv_q <= bus_req.wdata[`ODIV_MSB:`ODIV_LSB];
      end
   end

   // High-speed mode; the gate uses the enable as it stood before this write
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hmode_q <= `HMODE_RESET;
      end
      else if (wr_hcs_lo && !hoscen_q)
      begin
         hmode_q <= mode_next(hmode_q, bus_req.wdata[`HMODE_MSB:`HMODE_LSB]);
      end
   end

   // System clock select; cannot be set while the oscillator is off
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syssel_q <= `SYSSEL_RESET;
      end
      else if (wr_hcs_hi)
      begin
         syssel_q <= bus_req.wdata[`SYSSEL_BIT] & bus_req.wdata[`HOSCEN_BIT];
      end
      else if (!hoscen_q)
      begin
         syssel_q <= 1'b0;
      end
   end

   // High-speed oscillator enable
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hoscen_q <= `HOSCEN_RESET;
      end
      else if (wr_hcs_hi)
      begin
         hoscen_q <= bus_req.wdata[`HOSCEN_BIT];
      end
   end

   // Low-speed crystal permit for the timer block
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         permit_q <= `LPERMIT_RESET;
      end
      else if (wr_hcs_hi)
      begin
         permit_q <= bus_req.wdata[`LPERMIT_BIT];
      end
   end

   // Unused high-byte bits read back what was written
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         spare_q <= '0;
      end
      else if (wr_hcs_hi)
      begin
         spare_q <= {bus_req.wdata[13:12], bus_req.wdata[10]};
      end
   end

   // Low-speed mode field
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lmode_q <= `LMODE_RESET;
      end
      else if (wr_lcs_lo)
      begin
         lmode_q <= mode_next(lmode_q, bus_req.wdata[`LMODE_MSB:`LMODE_LSB]);
      end
   end

   // Filter selects and the rest of the low-speed register
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lcs_store_q <= '0;
      end
      else
      begin
         if (wr_lcs_lo)
         begin
            lcs_store_q[5:0] <= bus_req.wdata[7:2];
         end
         if (wr_lcs_hi)
         begin
            lcs_store_q[13:6] <= bus_req.wdata[15:8];
         end
      end
   end

   // Shared prescaler; runs only while the high-speed oscillator runs
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pre_q <= '0;
      end
      else if (hoscen_q)
      begin
         pre_q <= pre_q + `PRESCALE_W'(1);
      end
   end

   // New rates load at the common period boundary, or at once while the oscillator is off, so no pulse is cut short
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hdiv_act_q <= `HDIV_RESET;
         odiv_act_q <= `ODIV_RESET;
      end
      else if (rate_load)
      begin
         hdiv_act_q <= hdiv_q;
         odiv_act_q <= odiv_q;
      end
   end

   // Source switches only on a low-speed edge; dropping the oscillator is immediate
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         src_q <= SRC_HIGH;
      end
      else if (!hoscen_q)
      begin
         src_q <= SRC_LOW;
      end
      else if (ls_sel_tick)
      begin
         src_q <= syssel_q ? SRC_HIGH : SRC_LOW;
      end
   end

   // Stability flags follow the crystal oscillators that are actually running
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hstab_q <= 1'b0;
         lstab_q <= 1'b0;
      end
      else
      begin
         hstab_q <= hs_osc_stable && hoscen_q && (hmode_q == `MODE_XTAL);
         lstab_q <= ls_osc_stable && ls_xtal_on(permit_q, lmode_q);
      end
   end

   // Registered clock enables
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         clk_en <= '0;
      end
      else
      begin
         clk_en.hs <= hoscen_q && hs_tick;
         clk_en.port_out <= hoscen_q && out_tick;
         clk_en.sys <= (src_q == SRC_HIGH) ? (hoscen_q && hs_tick) : ls_sel_tick;
         clk_en.peri_ls <= ls_sel_tick;
         clk_en.timer_ls <= permit_q ? ls_xtal_tick : ls_sel_tick;
      end
   end

   // Oscillator control toward the analog side
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         osc_ctl <= '0;
      end
      else
      begin
         osc_ctl.hs_osc_run <= hoscen_q;
         osc_ctl.hs_mode <= hmode_q;
         osc_ctl.ls_xtal_run <= ls_xtal_on(permit_q, lmode_q);
         osc_ctl.ls_mode <= lmode_q;
         osc_ctl.ls_filter <= lcs_word[`LFLT_BIT];
         osc_ctl.hs_filter <= lcs_word[`HFLT_MSB:`HFLT_LSB];
      end
   end

   // Read data in the cycle after the strobe; unmapped reads return zero
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_rdata <= '0;
      end
      else if (!bus_req.rd)
      begin
         bus_rdata <= '0;
      end
      else if (reg_hit(bus_req.addr, `HCS_ADDR))
      begin
         bus_rdata <= hcs_word;
      end
      else if (reg_hit(bus_req.addr, `LCS_ADDR))
      begin
         bus_rdata <= lcs_word;
      end
      else
      begin
         bus_rdata <= '0;
      end
   end

endmodule // hs_clock_system_select

`default_nettype wire

/* File: dv/hs_clock_system_select_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module hs_clock_system_select_checker
   import hs_clock_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Register port
   input wire reg_req_t bus_req,
   input wire logic [15:0] bus_rdata,
   // Sources and status
   input wire logic ls_sel_tick,
   input wire logic ls_xtal_tick,
   input wire logic hs_osc_stable,
   input wire logic ls_osc_stable,
   // Enables and control
   input wire clk_en_t clk_en,
   input wire osc_ctl_t osc_ctl
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Outputs are still zero at the first edge after release
   property p_hs_mode_set;
      $past(nrst) |-> osc_ctl.hs_mode != 2'h0;
   endproperty
   a_hs_mode_set: assert property (p_hs_mode_set) else $error("hs mode zero");
   property p_ls_mode_set;
      $past(nrst) |-> osc_ctl.ls_mode != 2'h0;
   endproperty
   a_ls_mode_set: assert property (p_ls_mode_set) else $error("ls mode zero");
   property p_mode_locked;
      osc_ctl.hs_osc_run [*3] |-> $stable(osc_ctl.hs_mode);
   endproperty
   a_mode_locked: assert property (p_mode_locked) else $error("hs mode changed while running");
   property p_hs_stop;
      !osc_ctl.hs_osc_run [*2] |-> !clk_en.hs;
   endproperty
   a_hs_stop: assert property (p_hs_stop) else $error("hs pulse while stopped");
   property p_peri;
      $past(nrst) |-> clk_en.peri_ls == $past(ls_sel_tick);
   endproperty
   a_peri: assert property (p_peri) else $error("peripheral ls clock wrong");
   property p_timer_xtal;
      osc_ctl.ls_xtal_run [*3] ##0 osc_ctl.ls_mode == 2'h2 |-> clk_en.timer_ls == $past(ls_xtal_tick);
   endproperty
   a_timer_xtal: assert property (p_timer_xtal) else $error("timer not on crystal");
   property p_timer_sel;
      !osc_ctl.ls_xtal_run [*3] |-> clk_en.timer_ls == $past(ls_sel_tick);
   endproperty
   a_timer_sel: assert property (p_timer_sel) else $error("timer not on ls clock");
   property p_sys_low;
      !osc_ctl.hs_osc_run [*3] |-> clk_en.sys == $past(ls_sel_tick);
   endproperty
   a_sys_low: assert property (p_sys_low) else $error("system clock not low speed");
   property p_reset_mode;
      $rose(nrst) |=> osc_ctl.hs_mode == 2'h2 && osc_ctl.hs_osc_run;
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("reset mode wrong");
   c_hs: cover property (clk_en.hs);
   c_xtal: cover property (osc_ctl.ls_xtal_run && clk_en.timer_ls);
   c_read: cover property (bus_req.rd ##1 bus_rdata != 16'h0);
endmodule // hs_clock_system_select_checker
bind hs_clock_system_select hs_clock_system_select_checker u_chk (.sys_clk, .nrst, .bus_req, .bus_rdata,
   .ls_sel_tick, .ls_xtal_tick, .hs_osc_stable, .ls_osc_stable, .clk_en, .osc_ctl);
`default_nettype wire

/* File: dv/tb_hs_clock_system_select.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_hs_clock_system_select
   import hs_clock_pkg::*;
;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   reg_req_t bus_req = '0;
   logic ls_sel_tick = 1'b0;
   logic ls_xtal_tick = 1'b0;
   logic hs_osc_stable = 1'b1;
   logic ls_osc_stable = 1'b1;
   logic [15:0] bus_rdata;
   logic [7:0] tc = 8'h00;
   clk_en_t clk_en;
   osc_ctl_t osc_ctl;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   int nhs;
   int nout;
   int nsys;
   hs_clock_system_select dut (.sys_clk, .nrst, .bus_req, .bus_rdata, .ls_sel_tick, .ls_xtal_tick,
      .hs_osc_stable, .ls_osc_stable, .clk_en, .osc_ctl);
   always #5 sys_clk = ~sys_clk;
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Unequal low-speed tick rates tell the two timer sources apart
   always @(posedge sys_clk)
   begin
      tc <= tc + 8'h01;
      ls_sel_tick <= (tc[1:0] == 2'h3);
      ls_xtal_tick <= (tc % 8'h07 == 8'h00);
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checked++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, byte_en: be, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 chk("rdata", e & m, bus_rdata & m);
   endtask
   initial
   begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(16'hf002, 16'hffff, 16'h0373);
      rd(16'hf004, 16'hffff, 16'h0002);
      wr(16'hf002, 16'h000b, 2'h1);
      rd(16'hf002, 16'hffff, 16'h0313);
      wr(16'hf002, 16'h0000, 2'h2);
      rd(16'hf002, 16'hffff, 16'h0013);
      wr(16'hf002, 16'h0004, 2'h1);
      rd(16'hf002, 16'hffff, 16'h0014);
      wr(16'hf002, 16'h000b, 2'h1);
      wr(16'hf002, 16'h0300, 2'h2);
      rd(16'hf002, 16'hffff, 16'h830b);
      chk("hs mode", 16'h0001, 16'(osc_ctl.hs_mode));
      wr(16'hf002, 16'h0200, 2'h2);
      rd(16'hf002, 16'hffff, 16'h820b);
      wr(16'hf002, 16'h0b00, 2'h2);
      rd(16'hf002, 16'hffff, 16'hcb0b);
      @(posedge sys_clk);
      ls_osc_stable <= 1'b0;
      hs_osc_stable <= 1'b0;
      rd(16'hf002, 16'hffff, 16'h0b0b);
      wr(16'hf004, 16'h00d0, 2'h3);
      rd(16'hf004, 16'hffff, 16'h00d2);
      chk("osc ctl", 16'h0177, 16'(osc_ctl));
      wr(16'hf006, 16'hffff, 2'h3);
      rd(16'hf006, 16'hffff, 16'h0000);
      for (int c = 0; c < 8; c++)
      begin
         wr(16'hf002, 16'(c * 33), 2'h1);
         rd(16'hf002, 16'h00e7, 16'(c * 33));
         // New codes load only at prescaler wrap, so let one wrap pass
         repeat (40) @(posedge sys_clk);
         nhs = 0;
         nout = 0;
         nsys = 0;
         repeat (64)
         begin
            @(posedge sys_clk);
            #1;
            nhs += clk_en.hs;
            nout += clk_en.port_out;
            nsys += clk_en.sys;
         end
         chk("sys pulses", 16'(64 >> ((c > 5) ? 5 : c)), 16'(nsys));
         chk("hs pulses", 16'(64 >> ((c > 5) ? 5 : c)), 16'(nhs));
         chk("out pulses", 16'(64 >> ((c > 5) ? 5 : c)), 16'(nout));
      end
      summarize();
   end
endmodule // tb_hs_clock_system_select
`default_nettype wire
